/* File: design/ebls_steer.v */
// endian byte-lane steering and access splitting, top module
// ----------------------------------------------------------------------
// Behaviour
// - endian mode taken from pin during reset
// - pin low big endian, high little
// - ordinary memory: byte, word, longword widths
// - sdram: only word and longword widths
// - pcmcia: only byte and word widths
// - wider accesses split automatically into beats
// - each beat sized to the smaller of request size and device width
// - big endian 32-bit lane placement
// - big endian 16-bit placement, upper half first
// - big endian 8-bit, msb first
// - little endian 32-bit lane placement
// - little endian 16-bit placement, lower half first
// - little endian 8-bit, lsb first
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "ebls_defs.vh"

module ebls_steer (
  input wire clock,
  input wire rstn,
  input wire ce,
  input wire endian_select_pin,
  input wire [1:0] dev_kind,
  input wire [1:0] dev_width,
  input wire req_valid,
  input wire req_write,
  input wire [1:0] req_size,
  input wire [31:0] req_addr,
  input wire [31:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg [31:0] rsp_rdata,
  output reg little_endian,
  output reg ext_valid,
  output reg ext_write,
  output reg [31:0] ext_addr,
  output reg [31:0] ext_wdata,
  input wire ext_done,
  input wire [31:0] ext_rdata,
  output reg write_strobe_lane3,
  output reg write_strobe_lane2,
  output reg write_strobe_lane1,
  output reg write_strobe_lane0,
  output reg sdram_mask_lane3,
  output reg sdram_mask_lane2,
  output reg sdram_mask_lane1,
  output reg sdram_mask_lane0
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_ISSUE = 3'b010;
  localparam ST_WAIT = 3'b100;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // bytes in a size code
  function [2:0] size_bytes;
    input [1:0] sz;
    begin
      case (sz)
        `EBLS_SZ_BYTE: size_bytes = 3'h1;
        `EBLS_SZ_WORD: size_bytes = 3'h2;
        default: size_bytes = 3'h4;
      endcase
    end
  endfunction

  // device width legal for the device kind
  function [1:0] legal_width;
    input [1:0] kind;
    input [1:0] w;
    begin
      legal_width = (w == 2'h3) ? `EBLS_SZ_LONG : w; // byte, word, longword
      case (kind)
        `EBLS_DEV_SDRAM:
          if (legal_width == `EBLS_SZ_BYTE)
            legal_width = `EBLS_SZ_WORD; // no byte-wide sdram
        `EBLS_DEV_PCMCIA:
          if (legal_width == `EBLS_SZ_LONG)
            legal_width = `EBLS_SZ_WORD; // no longword pcmcia
        default: ;
      endcase
    end
  endfunction

  // smaller of two size codes
  function [1:0] min_size;
    input [1:0] a;
    input [1:0] b;
    begin
      min_size = (a < b) ? a : b;
    end
  endfunction

  // index of the last beat: request bytes over device bytes, minus one
  function [1:0] beat_last;
    input [1:0] sz;
    input [1:0] w;
    reg [2:0] ratio;
    begin
      ratio = size_bytes(sz) / size_bytes(w);
      beat_last = 2'h0;
      if (sz > w)
        beat_last = ratio[1:0] - 2'h1;
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] width_reg;
  reg [1:0] kind_reg;
  reg write_reg;
  reg [1:0] size_reg;
  reg [31:0] base_reg;
  reg [31:0] wdata_reg;
  reg [31:0] gather_reg;
  reg [1:0] beat_reg;
  reg [1:0] beats_reg;
  wire little;

  // ----------------------------------------------------------------------
  // endian capture
  // ----------------------------------------------------------------------
  ebls_endian_latch u_latch (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .endian_select_pin(endian_select_pin),
    .little_reg(little)
  );

  // ----------------------------------------------------------------------
  // current beat: size, address and lane map
  // ----------------------------------------------------------------------
  reg [1:0] beat_size;
  reg [1:0] beat_off;
  reg [31:0] beat_addr;
  reg [1:0] base_lsb;
  wire [1:0] lane;
  wire [3:0] strobe;

  always @* begin
    beat_size = min_size(size_reg, width_reg); // beat of the smaller of request size and device width
    base_lsb = base_reg[1:0];
    beat_off = 2'h0;
    case (beat_size)
      `EBLS_SZ_BYTE: beat_off = beat_reg;
      `EBLS_SZ_WORD: beat_off = {beat_reg[0], 1'b0};
      default: beat_off = 2'h0;
    endcase
    beat_addr = {base_reg[31:2], base_lsb + beat_off}; // ascending addresses
  end

  ebls_lane_map u_map (
    .little(little),
    .width(width_reg),
    .addr(beat_addr[1:0]),
    .beat_size(beat_size),
    .lane(lane),
    .strobe(strobe)
  );

  // ----------------------------------------------------------------------
  // which byte of the internal value a beat carries (byte index 0 = lsb)
  // ----------------------------------------------------------------------
  reg [1:0] piece;
  reg [2:0] nbytes;
  reg [2:0] beat_bytes;
  reg [1:0] last_byte;
  reg [1:0] span;
  always @* begin
    nbytes = size_bytes(size_reg);
    beat_bytes = size_bytes(beat_size);
    last_byte = nbytes[1:0] - 2'h1; // wraps to 3 for a longword
    span = beat_bytes[1:0] - 2'h1;
    piece = 2'h0;
    if (beat_size != size_reg) begin
      if (little)
        piece = beat_off; // lsb first
      else
        piece = last_byte - beat_off - span; // msb first
    end
  end

  // ----------------------------------------------------------------------
  // write data placed on the lanes
  // ----------------------------------------------------------------------
  reg [31:0] shifted;
  reg [31:0] place;
  always @* begin
    shifted = wdata_reg >> {piece, 3'b000};
    place = 32'h00000000;
    case (beat_size)
      `EBLS_SZ_BYTE: place = {4{shifted[7:0]}} & ({{8{strobe[3]}}, {8{strobe[2]}},
                             {8{strobe[1]}}, {8{strobe[0]}}});
      `EBLS_SZ_WORD: place = strobe[3] ? {shifted[15:0], 16'h0000} : {16'h0000, shifted[15:0]};
      default: place = shifted;
    endcase
  end

  // ----------------------------------------------------------------------
  // read data picked from the lanes and merged
  // ----------------------------------------------------------------------
  reg [31:0] pick;
  reg [31:0] merged;
  always @* begin
    pick = 32'h00000000;
    case (beat_size)
      `EBLS_SZ_BYTE: pick = {24'h000000, ext_rdata[{lane, 3'b000} +: 8]};
      `EBLS_SZ_WORD: pick = strobe[3] ? {16'h0000, ext_rdata[31:16]} : {16'h0000, ext_rdata[15:0]};
      default: pick = ext_rdata;
    endcase
    merged = gather_reg | (pick << {piece, 3'b000}); // gather into place
  end

  // ----------------------------------------------------------------------
  // beat sequencing
  // ----------------------------------------------------------------------
  wire last_beat = (beat_reg == beats_reg);
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (req_valid) state_next = ST_ISSUE;
      ST_ISSUE: state_next = ST_WAIT;
      ST_WAIT: if (ext_done) state_next = last_beat ? ST_IDLE : ST_ISSUE;
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // main clocked process
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      width_reg <= `EBLS_SZ_LONG;
      kind_reg <= `EBLS_DEV_MEM;
      write_reg <= 1'b0;
      size_reg <= `EBLS_SZ_BYTE;
      base_reg <= `EBLS_DATA_RST;
      wdata_reg <= `EBLS_DATA_RST;
      gather_reg <= `EBLS_DATA_RST;
      beat_reg <= 2'h0;
      beats_reg <= 2'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= `EBLS_DATA_RST;
      little_endian <= 1'b0;
      ext_valid <= 1'b0;
      ext_write <= 1'b0;
      ext_addr <= `EBLS_DATA_RST;
      ext_wdata <= `EBLS_DATA_RST;
      {write_strobe_lane3, write_strobe_lane2, write_strobe_lane1, write_strobe_lane0}
        <= `EBLS_STRB_OFF;
      {sdram_mask_lane3, sdram_mask_lane2, sdram_mask_lane1, sdram_mask_lane0}
        <= `EBLS_STRB_OFF;
    end else if (ce) begin
      state_reg <= state_next;
      little_endian <= little;
      rsp_valid <= 1'b0;
      req_ready <= (state_next == ST_IDLE);
      case (state_reg)
        ST_IDLE: begin
          if (req_valid) begin
            width_reg <= legal_width(dev_kind, dev_width);
            kind_reg <= dev_kind;
            write_reg <= req_write;
            size_reg <= req_size;
            base_reg <= req_addr;
            wdata_reg <= req_wdata;
            gather_reg <= `EBLS_DATA_RST;
            beat_reg <= 2'h0;
            // beats = request bytes / device bytes, minus one
            beats_reg <= beat_last(min_size(req_size, `EBLS_SZ_LONG),
                                   legal_width(dev_kind, dev_width));
          end
        end
        ST_ISSUE: begin
          ext_valid <= 1'b1;
          ext_write <= write_reg;
          ext_addr <= beat_addr;
          ext_wdata <= place;
          if (kind_reg == `EBLS_DEV_SDRAM)
            {sdram_mask_lane3, sdram_mask_lane2, sdram_mask_lane1, sdram_mask_lane0}
              <= strobe;
          else
            {write_strobe_lane3, write_strobe_lane2, write_strobe_lane1, write_strobe_lane0}
              <= strobe;
        end
        ST_WAIT: begin
          if (ext_done) begin
            ext_valid <= 1'b0;
            {write_strobe_lane3, write_strobe_lane2, write_strobe_lane1, write_strobe_lane0}
              <= `EBLS_STRB_OFF;
            {sdram_mask_lane3, sdram_mask_lane2, sdram_mask_lane1, sdram_mask_lane0}
              <= `EBLS_STRB_OFF;
            gather_reg <= merged;
            beat_reg <= beat_reg + 2'h1;
            if (last_beat) begin
              rsp_valid <= 1'b1;
              rsp_rdata <= write_reg ? `EBLS_DATA_RST : merged; // whole value at once
            end
          end
        end
        default: ;
      endcase
    end
  end

endmodule // ebls_steer

`default_nettype wire

/* File: design/ebls_defs.vh */
// constants for the endian byte-lane steering block
`ifndef EBLS_DEFS_VH
`define EBLS_DEFS_VH

// ----------------------------------------------------------------------
// access sizes (internal) and device widths (external)
// ----------------------------------------------------------------------
`define EBLS_SZ_BYTE 2'h0
`define EBLS_SZ_WORD 2'h1
`define EBLS_SZ_LONG 2'h2

// ----------------------------------------------------------------------
// kinds of connected device
// ----------------------------------------------------------------------
`define EBLS_DEV_MEM 2'h0
`define EBLS_DEV_SDRAM 2'h1
`define EBLS_DEV_PCMCIA 2'h2

// ----------------------------------------------------------------------
// endian modes as captured from the select pin
// ----------------------------------------------------------------------
`define EBLS_BIG 1'h0
`define EBLS_LITTLE 1'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EBLS_STRB_OFF 4'h0
`define EBLS_DATA_RST 32'h00000000

`endif

/* File: design/ebls_lane_map.v */
// lane and strobe mapping for one external beat
`timescale 1ns/1ps
`default_nettype none
`include "ebls_defs.vh"

module ebls_lane_map (
  input wire little,
  input wire [1:0] width,
  input wire [1:0] addr,
  input wire [1:0] beat_size,
  output reg [1:0] lane,
  output reg [3:0] strobe
);

  // ----------------------------------------------------------------------
  // lane of the byte at a given offset, for byte, word and longword devices
  // ----------------------------------------------------------------------
  always @* begin
    lane = 2'h0;
    strobe = `EBLS_STRB_OFF;
    case (width)
      `EBLS_SZ_BYTE: begin
        lane = 2'h0; // byte device uses the lowest lane only
        strobe = 4'h1;
      end
      `EBLS_SZ_WORD: begin
        if (little)
          lane = {1'b0, addr[0]}; // odd bytes high lane
        else
          lane = {1'b0, ~addr[0]}; // even bytes high lane
        if (beat_size == `EBLS_SZ_BYTE)
          strobe = 4'h1 << lane; // only the active lane strobes
        else
          strobe = 4'h3;
      end
      default: begin
        if (little)
          lane = addr;
        else
          lane = ~addr;
        if (beat_size == `EBLS_SZ_BYTE)
          strobe = 4'h1 << lane;
        else if (beat_size == `EBLS_SZ_WORD)
          strobe = (little ^ addr[1]) ? 4'h3 : 4'hC; // upper pair: big at 0, little at 2
        else
          strobe = 4'hF;
      end
    endcase
  end

endmodule // ebls_lane_map

`default_nettype wire

/* File: design/ebls_endian_latch.v */
// capture of the endian select pin during reset, on enabled clocks only
`timescale 1ns/1ps
`default_nettype none
`include "ebls_defs.vh"

module ebls_endian_latch (
  input wire clock,
  input wire rstn,
  input wire ce,
  input wire endian_select_pin,
  output reg little_reg
);

  // ----------------------------------------------------------------------
  // sample the pin on every enabled clock while reset is held, then hold it
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (ce && !rstn)
      little_reg <= endian_select_pin; // low big, high little
  end

endmodule // ebls_endian_latch

`default_nettype wire

/* File: tb/ebls_steer_props.sv */
// assertion checker for the lane steering block
`timescale 1ns/1ps
`default_nettype none
`include "ebls_defs.vh"

module ebls_steer_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic little_endian,
  input wire logic [1:0] dev_kind,
  input wire logic ext_valid,
  input wire logic ext_write,
  input wire logic [31:0] ext_addr,
  input wire logic [31:0] ext_wdata,
  input wire logic ext_done,
  input wire logic write_strobe_lane3,
  input wire logic write_strobe_lane2,
  input wire logic write_strobe_lane1,
  input wire logic write_strobe_lane0,
  input wire logic sdram_mask_lane3,
  input wire logic sdram_mask_lane2,
  input wire logic sdram_mask_lane1,
  input wire logic sdram_mask_lane0
);
  // ----------------------------------------------------------------------
  // lane groups
  // ----------------------------------------------------------------------
  wire [3:0] wstrb = {write_strobe_lane3, write_strobe_lane2, write_strobe_lane1, write_strobe_lane0};
  wire [3:0] mask = {sdram_mask_lane3, sdram_mask_lane2, sdram_mask_lane1, sdram_mask_lane0};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // request taken and beat finished
  sequence taken_s;
    req_valid && req_ready && ce;
  endsequence
  sequence beat_done_s;
    ext_valid && ext_done;
  endsequence

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  busy_refuse_a: assert property (taken_s |=> !req_ready)
    else $error("ready stayed high after take");
  beat_launch_a: assert property (taken_s |-> ##2 ext_valid)
    else $error("beat not launched two edges after take");
  beat_hold_a: assert property (ext_valid && !ext_done |=>
    ext_valid && $stable(ext_addr) && $stable(ext_wdata) && $stable(ext_write))
    else $error("beat changed before done");
  beat_close_a: assert property (beat_done_s |=> !ext_valid && wstrb == 4'h0 && mask == 4'h0)
    else $error("beat not closed after done");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  strobe_idle_a: assert property (!ext_valid |-> wstrb == 4'h0 && mask == 4'h0)
    else $error("lane strobe outside a beat");
  group_excl_a: assert property (ext_valid |-> wstrb == 4'h0 || mask == 4'h0)
    else $error("both strobe groups active");
  sdram_width_a: assert property (ext_valid && dev_kind == `EBLS_DEV_SDRAM |->
    $countones(mask) inside {1, 2, 4} && (mask != 4'h1 || ext_addr[0] != little_endian))
    else $error("sdram beat laid out for a byte device");
  pcmcia_width_a: assert property (ext_valid && ext_write && dev_kind == `EBLS_DEV_PCMCIA |->
    $countones(wstrb) inside {1, 2})
    else $error("card beat wider than a word");
  endian_hold_a: assert property (rstn && $past(rstn) && $past(rstn, 2) |->
    $stable(little_endian))
    else $error("endian mode changed outside reset");
endmodule // ebls_steer_chk

bind ebls_steer ebls_steer_chk i_chk (.clock(clock), .rstn(rstn), .ce(ce), .req_valid(req_valid),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .little_endian(little_endian),
  .dev_kind(dev_kind), .ext_valid(ext_valid), .ext_write(ext_write), .ext_addr(ext_addr),
  .ext_wdata(ext_wdata), .ext_done(ext_done), .write_strobe_lane3(write_strobe_lane3),
  .write_strobe_lane2(write_strobe_lane2), .write_strobe_lane1(write_strobe_lane1),
  .write_strobe_lane0(write_strobe_lane0), .sdram_mask_lane3(sdram_mask_lane3),
  .sdram_mask_lane2(sdram_mask_lane2), .sdram_mask_lane1(sdram_mask_lane1),
  .sdram_mask_lane0(sdram_mask_lane0));
`default_nettype wire

/* File: tb/ebls_ext_mem.sv */
// external memory model answering the steered beats
`timescale 1ns/1ps
`default_nettype none

module ebls_ext_mem (
  input wire logic clock,
  input wire logic slow,
  input wire logic ext_valid,
  input wire logic ext_write,
  input wire logic [31:0] ext_addr,
  input wire logic [31:0] ext_wdata,
  input wire logic [3:0] lanes,
  output logic ext_done,
  output logic [31:0] ext_rdata
);
  logic [31:0] mem [0:15];
  logic [2:0] wait_cnt;

  initial begin
    ext_done = 1'b0;
    ext_rdata = 32'h5A5A5A5A;
    wait_cnt = 3'h0;
    for (int i = 0; i < 16; i++) mem[i] = 32'hC3C3C3C3;
  end

  // answer each beat at once or after three waits; data bus toggles when released
  always @(posedge clock) begin
    ext_done <= 1'b0;
    ext_rdata <= ~ext_rdata;
    if (ext_valid && !ext_done) begin
      wait_cnt <= wait_cnt + 3'h1;
      if (!slow || wait_cnt == 3'h3) begin
        ext_done <= 1'b1;
        wait_cnt <= 3'h0;
        ext_rdata <= mem[ext_addr[3:0]];
        if (ext_write) begin
          for (int k = 0; k < 4; k++) begin
            if (lanes[k]) mem[ext_addr[3:0]][8*k +: 8] <= ext_wdata[8*k +: 8];
          end
        end
      end
    end
  end
endmodule // ebls_ext_mem
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the lane steering block
`timescale 1ns/1ps
`default_nettype none
`include "ebls_defs.vh"

module testbench;
  logic clock, rstn, ce, endian_select_pin, slow, little_mode;
  logic [1:0] dev_kind, dev_width, req_size;
  logic req_valid, req_write, req_ready, rsp_valid, little_endian, ext_valid, ext_write, ext_done;
  logic [31:0] req_addr, req_wdata, rsp_rdata, ext_addr, ext_wdata, ext_rdata;
  wire [3:0] wstrb, mask;
  logic [31:0] q_addr[$], q_data[$];
  logic [8:0] q_strb[$];
  int bad_count = 0, tests_run = 0, cycles = 0;

  ebls_steer i_ebls_steer (.clock(clock), .rstn(rstn), .ce(ce),
    .endian_select_pin(endian_select_pin), .dev_kind(dev_kind), .dev_width(dev_width),
    .req_valid(req_valid), .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .little_endian(little_endian), .ext_valid(ext_valid), .ext_write(ext_write),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_done(ext_done), .ext_rdata(ext_rdata),
    .write_strobe_lane3(wstrb[3]), .write_strobe_lane2(wstrb[2]),
    .write_strobe_lane1(wstrb[1]), .write_strobe_lane0(wstrb[0]),
    .sdram_mask_lane3(mask[3]), .sdram_mask_lane2(mask[2]),
    .sdram_mask_lane1(mask[1]), .sdram_mask_lane0(mask[0]));

  ebls_ext_mem i_ebls_ext_mem (.clock(clock), .slow(slow), .ext_valid(ext_valid),
    .ext_write(ext_write), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .lanes(wstrb | mask),
    .ext_done(ext_done), .ext_rdata(ext_rdata));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // beat monitor and hang limit
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (ext_valid && ext_done) begin
      q_addr.push_back(ext_addr);
      q_data.push_back(ext_wdata);
      q_strb.push_back({ext_write, wstrb, mask});
    end
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // effective device width in bytes
  function automatic int eff(input logic [1:0] kind, w);
    if (kind == `EBLS_DEV_SDRAM && w == `EBLS_SZ_BYTE) return 2;
    if (kind == `EBLS_DEV_PCMCIA && w == `EBLS_SZ_LONG) return 2;
    return 1 << w;
  endfunction

  task automatic do_reset(input logic pin);
    rstn <= 1'b0;
    endian_select_pin <= pin;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    endian_select_pin <= ~pin;
    little_mode = pin;
    @(posedge clock);
    @(posedge clock);
    check({31'h0, little_endian}, {31'h0, pin}, "endian mode");
  endtask

  task automatic access(input logic w, input logic [1:0] sz, input logic [31:0] a, d,
                        output logic [31:0] r);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    req_valid <= 1'b1;
    req_write <= w;
    req_size <= sz;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check(32'(n < 200), 32'h1, "answer");
    r = rsp_rdata;
  endtask

  // write then read back one access, checking every write beat
  task automatic run_case(input logic [1:0] kind, w, sz, input logic [31:0] a, d);
    int nb, dw, bs, nbeat, low, ba;
    logic [31:0] v, r, piece, mk;
    logic [3:0] st;
    logic [8:0] ls;
    nb = 1 << sz;
    dw = eff(kind, w);
    bs = nb < dw ? nb : dw;
    nbeat = nb / bs;
    v = (nb == 4) ? d : d & ((32'h1 << (8 * nb)) - 32'h1);
    dev_kind <= kind;
    dev_width <= w;
    access(1'b1, sz, a, v, r);
    check(r, 32'h0, "write answer");
    check(32'(q_addr.size()), 32'(nbeat), "write beats");
    for (int k = 0; k < nbeat && k < q_addr.size(); k++) begin
      ba = a + k * bs;
      low = little_mode ? ba % dw : dw - ba % dw - bs;
      piece = little_mode ? v >> (8 * bs * k) : v >> (8 * (nb - bs * (k + 1)));
      st = 4'((1 << bs) - 1) << low;
      for (int j = 0; j < 4; j++) mk[8*j +: 8] = {8{st[j]}};
      ls = (kind == `EBLS_DEV_SDRAM) ? {1'b1, 4'h0, st} : {1'b1, st, 4'h0};
      check(q_addr[k], 32'(ba), "beat address");
      check({23'h0, q_strb[k]}, {23'h0, ls}, "lanes");
      check(q_data[k] & mk, (piece << (8 * low)) & mk, "lane data");
    end
    q_addr.delete();
    q_data.delete();
    q_strb.delete();
    access(1'b0, sz, a, 32'h0, r);
    check(32'(q_addr.size()), 32'(nbeat), "read beats");
    check({31'h0, q_strb[0][8]}, 32'h0, "read direction");
    check(r, v, "read value");
    q_addr.delete();
    q_data.delete();
    q_strb.delete();
  endtask

  // a request offered while the clock enable is low is not taken
  task automatic test_freeze();
    ce <= 1'b0;
    req_valid <= 1'b1;
    req_write <= 1'b1;
    repeat (3) @(posedge clock);
    req_valid <= 1'b0;
    ce <= 1'b1;
    @(posedge clock);
    check({31'h0, req_ready}, 32'h1, "frozen ready");
    check({31'h0, ext_valid}, 32'h0, "frozen beat");
  endtask

  // every width, size and aligned offset of ordinary memory in one endian mode
  task automatic test_mode(input logic pin);
    do_reset(pin);
    test_freeze();
    for (int w = 0; w < 3; w++) begin
      for (int a = 0; a < 4; a++) begin
        run_case(`EBLS_DEV_MEM, 2'(w), `EBLS_SZ_BYTE, 32'(a), 32'h8C4B2A17 + 32'(a));
        if (a % 2 == 0) run_case(`EBLS_DEV_MEM, 2'(w), `EBLS_SZ_WORD, 32'(a), 32'hE61D5F93);
      end
      run_case(`EBLS_DEV_MEM, 2'(w), `EBLS_SZ_LONG, 32'h4, 32'hA1B2C3D4);
    end
  endtask

  // sdram and card widths, including the remapped ones, with a slow far side
  task automatic test_kinds();
    slow <= 1'b1;
    for (int w = 0; w < 3; w++) begin
      run_case(`EBLS_DEV_SDRAM, 2'(w), `EBLS_SZ_LONG, 32'h8, 32'h13579BDF);
      run_case(`EBLS_DEV_SDRAM, 2'(w), `EBLS_SZ_BYTE, 32'h3, 32'h0000005E);
      run_case(`EBLS_DEV_PCMCIA, 2'(w), `EBLS_SZ_LONG, 32'hC, 32'h2468ACE0);
      run_case(`EBLS_DEV_PCMCIA, 2'(w), `EBLS_SZ_WORD, 32'h2, 32'h00007F31);
    end
    slow <= 1'b0;
  endtask

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    endian_select_pin = 1'b0;
    slow = 1'b0;
    little_mode = 1'b0;
    dev_kind = `EBLS_DEV_MEM;
    dev_width = `EBLS_SZ_LONG;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_size = `EBLS_SZ_BYTE;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    test_mode(1'b0);
    test_kinds();
    test_mode(1'b1);
    test_kinds();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
